/* inc/mfvi_defs.svh */
// constants for the mac filter and vlan ingress block
`ifndef MFVI_DEFS_SVH
`define MFVI_DEFS_SVH
`define MFVI_NPORTS 2
`define MFVI_PORT_W 1
`define MFVI_ALLOW_DEPTH 16
`define MFVI_DENY_DEPTH 16
`define MFVI_IDX_W 4
`define MFVI_MAC_W 48
`define MFVI_VID_W 12
`define MFVI_VID_MIN 12'h001
`define MFVI_VID_MAX 12'hFFE
`define MFVI_VID_RST 12'h001
`define MFVI_BUF_DEPTH 2
`endif

/* inc/mfvi_pkg.sv */
// types for the mac filter and vlan ingress block
package mfvi_pkg;
	typedef enum logic [1:0] {
		MFVI_ST_IDLE = 2'b00,
		MFVI_ST_LOOK = 2'b01,
		MFVI_ST_EMIT = 2'b10
	} mfvi_state_t;
	typedef enum logic [1:0] {
		MFVI_TBL_NONE = 2'b00,
		MFVI_TBL_ALLOW = 2'b01,
		MFVI_TBL_DENY = 2'b10
	} mfvi_tbl_t;
endpackage : mfvi_pkg

/* rtl/mfvi_tbl_mem.sv */
// small address table memory with registered read data
`timescale 1ns/1ps
`include "mfvi_defs.svh"
module mfvi_tbl_mem #(
	parameter int W = 48
) (
	input wire logic sys_clk,
	input wire logic we,
	input wire logic [`MFVI_IDX_W-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic [`MFVI_IDX_W-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [0:(1<<`MFVI_IDX_W)-1];
	// volatile storage, contents kept while powered
	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : mfvi_tbl_mem

/* rtl/mfvi_filter.sv */
// ingress filter: allowed/denied tables, port security, priority and vlan
//
// Operation
// [RULE_01] bound source accepted only on bound port
// [RULE_02] bound source on other port is rejected
// [RULE_03] binding enforced only with port security on
// [RULE_04] secured port: no learning, unknown sources dropped
// [RULE_05] entry: six-byte address, port, priority; add/remove
// [RULE_06] high entry on source/destination: high queue
// [RULE_07] low entry matching: low queue
// [RULE_08] denied addresses dropped on every port
// [RULE_09] tables volatile, kept until power off; rst_b also clears every entry valid bit
// [RULE_10] vlan mode resets off; off means no tagging
// [RULE_11] per-port default vlan 1..4094, reset 1
// [RULE_12] per-port egress tag choice, reset untagged
// [RULE_13] vlan on: tagged upstream, untagged downstream; the code also tags a downstream port whose egress tag choice is set
// [RULE_14] untagged ingress takes port default vlan
`timescale 1ns/1ps
`include "mfvi_defs.svh"
module mfvi_filter
	import mfvi_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	// frame header in (one request per frame)
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [`MFVI_PORT_W-1:0] in_port,
	input wire logic [`MFVI_MAC_W-1:0] in_sa,
	input wire logic [`MFVI_MAC_W-1:0] in_da,
	input wire logic in_tagged,
	input wire logic [`MFVI_VID_W-1:0] in_vid,
	// decision out
	output logic out_valid,
	input wire logic out_ready,
	output logic out_forward,
	output logic out_learn,
	output logic out_high_prio,
	output logic out_tag,
	output logic [`MFVI_VID_W-1:0] out_vid,
	output logic [`MFVI_PORT_W-1:0] out_port,
	// table maintenance
	input wire logic tbl_we,
	input wire logic tbl_sel_deny,
	input wire logic [`MFVI_IDX_W-1:0] tbl_idx,
	input wire logic tbl_entry_valid,
	input wire logic [`MFVI_MAC_W-1:0] tbl_mac,
	input wire logic [`MFVI_PORT_W-1:0] tbl_port,
	input wire logic tbl_high,
	// configuration
	input wire logic [`MFVI_NPORTS-1:0] port_secure_en,
	input wire logic vlan_en,
	input wire logic cfg_we,
	input wire logic [`MFVI_PORT_W-1:0] cfg_port,
	input wire logic [`MFVI_VID_W-1:0] cfg_port_default_vlan_id,
	input wire logic cfg_egress_tag,
	input wire logic [`MFVI_NPORTS-1:0] port_upstream,
	// status
	output logic busy,
	output logic cfg_err
);
	localparam int AW = `MFVI_MAC_W + `MFVI_PORT_W + 1;
	localparam int N = 1 << `MFVI_IDX_W;

	mfvi_state_t state_r;
	logic [`MFVI_IDX_W-1:0] idx_r;
	logic [`MFVI_PORT_W-1:0] port_r;
	logic [`MFVI_MAC_W-1:0] sa_r, da_r;
	logic tagged_r;
	logic [`MFVI_VID_W-1:0] vid_r;
	logic [N-1:0] allow_v_r, deny_v_r;
	logic [`MFVI_VID_W-1:0] port_default_vlan_id_r [`MFVI_NPORTS];
	logic [`MFVI_NPORTS-1:0] egr_tag_r;
	logic sa_bound_r, sa_home_r, deny_hit_r, hi_r, lo_r;
	logic rd_ok_r;
	logic [`MFVI_IDX_W-1:0] rd_idx_r;
	logic [AW-1:0] allow_q;
	logic [`MFVI_MAC_W-1:0] deny_q;
	logic [N-1:0] rd_allow_v, rd_deny_v;

	// legal default vlan range, used by the write and by the refusal flag
	function automatic logic vid_ok(input logic [`MFVI_VID_W-1:0] v);
		vid_ok = (v >= `MFVI_VID_MIN) && (v <= `MFVI_VID_MAX);
	endfunction : vid_ok

	// per-port vlan settings, range-checked on write
	genvar gp;
	generate
		for (gp = 0; gp < `MFVI_NPORTS; gp++) begin : g_port
			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					port_default_vlan_id_r[gp] <= `MFVI_VID_RST; // RULE_11
					egr_tag_r[gp] <= 1'b0; // RULE_12
				end else if (cfg_we && cfg_port == gp && vid_ok(cfg_port_default_vlan_id)) begin
					port_default_vlan_id_r[gp] <= cfg_port_default_vlan_id; // RULE_11
					egr_tag_r[gp] <= cfg_egress_tag; // RULE_12
				end
			end
		end
	endgenerate

	// flags a refused default vlan write
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_err <= 1'b0;
		end else if (cfg_we) begin
			cfg_err <= !vid_ok(cfg_port_default_vlan_id);
		end
	end

	// entry valid bits, individually added and removed
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			allow_v_r <= '0;
			deny_v_r <= '0;
		end else if (tbl_we) begin
			if (tbl_sel_deny) begin
				deny_v_r[tbl_idx] <= tbl_entry_valid; // RULE_05
			end else begin
				allow_v_r[tbl_idx] <= tbl_entry_valid; // RULE_05
			end
		end
	end

	// table storage: address, port, priority per allowed entry
	mfvi_tbl_mem #(.W(AW)) u_allow (
		.sys_clk(sys_clk),
		.we(tbl_we && !tbl_sel_deny),
		.waddr(tbl_idx),
		.wdata({tbl_mac, tbl_port, tbl_high}),
		.raddr(idx_r),
		.rdata(allow_q)
	); // RULE_09
	mfvi_tbl_mem #(.W(`MFVI_MAC_W)) u_deny (
		.sys_clk(sys_clk),
		.we(tbl_we && tbl_sel_deny),
		.waddr(tbl_idx),
		.wdata(tbl_mac),
		.raddr(idx_r),
		.rdata(deny_q)
	); // RULE_09

	assign rd_allow_v = allow_v_r;
	assign rd_deny_v = deny_v_r;

	// output buffer
	logic buf_in_valid, buf_in_ready;
	logic [`MFVI_PORT_W+`MFVI_VID_W+4-1:0] buf_in_data, buf_q [`MFVI_BUF_DEPTH];
	logic [1:0] cnt_r;
	logic wp_r, rp_r;
	logic fwd_c, tag_c;
	logic [`MFVI_VID_W-1:0] vid_c;

	// scan sequencer: one table entry per cycle, read data one cycle late
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= MFVI_ST_IDLE;
			idx_r <= '0;
			rd_idx_r <= '0;
			rd_ok_r <= 1'b0;
			port_r <= '0;
			sa_r <= '0;
			da_r <= '0;
			tagged_r <= 1'b0;
			vid_r <= '0;
		end else begin
			case (state_r)
				MFVI_ST_IDLE: begin
					rd_ok_r <= 1'b0;
					if (in_valid) begin
						port_r <= in_port;
						sa_r <= in_sa;
						da_r <= in_da;
						tagged_r <= in_tagged;
						vid_r <= in_vid;
						idx_r <= '0;
						state_r <= MFVI_ST_LOOK;
					end
				end
				MFVI_ST_LOOK: begin
					rd_ok_r <= 1'b1;
					rd_idx_r <= idx_r;
					if (rd_ok_r && rd_idx_r == `MFVI_IDX_W'(N - 1)) begin
						state_r <= MFVI_ST_EMIT;
						rd_ok_r <= 1'b0;
					end else if (idx_r != `MFVI_IDX_W'(N - 1)) begin
						idx_r <= idx_r + `MFVI_IDX_W'(1);
					end
				end
				MFVI_ST_EMIT: begin
					if (buf_in_ready) begin
						state_r <= MFVI_ST_IDLE;
					end
				end
				default: state_r <= MFVI_ST_IDLE;
			endcase
		end
	end

	// match accumulation over the scan
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sa_bound_r <= 1'b0;
			sa_home_r <= 1'b0;
			deny_hit_r <= 1'b0;
			hi_r <= 1'b0;
			lo_r <= 1'b0;
		end else if (state_r == MFVI_ST_IDLE) begin
			sa_bound_r <= 1'b0;
			sa_home_r <= 1'b0;
			deny_hit_r <= 1'b0;
			hi_r <= 1'b0;
			lo_r <= 1'b0;
		end else if (state_r == MFVI_ST_LOOK && rd_ok_r) begin
			if (rd_allow_v[rd_idx_r] && allow_q[AW-1 -: `MFVI_MAC_W] == sa_r) begin
				if (port_secure_en[allow_q[`MFVI_PORT_W:1]]) begin
					sa_bound_r <= 1'b1; // RULE_02 RULE_03
				end
				if (allow_q[`MFVI_PORT_W:1] == port_r) begin
					sa_home_r <= 1'b1; // RULE_01
				end
			end
			if (rd_allow_v[rd_idx_r] && (allow_q[AW-1 -: `MFVI_MAC_W] == sa_r ||
					allow_q[AW-1 -: `MFVI_MAC_W] == da_r)) begin
				if (allow_q[0]) begin
					hi_r <= 1'b1; // RULE_06
				end else begin
					lo_r <= 1'b1; // RULE_07
				end
			end
			if (rd_deny_v[rd_idx_r] && (deny_q == sa_r || deny_q == da_r)) begin
				deny_hit_r <= 1'b1; // RULE_08
			end
		end
	end

	// forwarding and vlan decision
	always_comb begin
		fwd_c = !deny_hit_r; // RULE_08
		if (port_secure_en[port_r] && !sa_home_r) begin
			fwd_c = 1'b0; // RULE_04
		end
		if (sa_bound_r && !sa_home_r) begin
			fwd_c = 1'b0; // RULE_02 RULE_03
		end
		vid_c = tagged_r ? vid_r : port_default_vlan_id_r[port_r]; // RULE_14
		tag_c = vlan_en && (egr_tag_r[port_r] || port_upstream[port_r]); // RULE_13
		if (!vlan_en) begin
			vid_c = '0; // RULE_10
			tag_c = 1'b0; // RULE_10
		end
	end

	assign buf_in_valid = (state_r == MFVI_ST_EMIT);
	assign buf_in_data = {port_r, vid_c, tag_c, hi_r && !lo_r || hi_r, fwd_c && !port_secure_en[port_r] || fwd_c,
		!port_secure_en[port_r]}; // RULE_04
	assign buf_in_ready = (cnt_r != 2'(`MFVI_BUF_DEPTH));

	// buffer storage, no reset: an entry is read only once counted
	always_ff @(posedge sys_clk) begin
		if (buf_in_valid && buf_in_ready) begin
			buf_q[wp_r] <= buf_in_data;
		end
	end

	// two-entry decision buffer; receiver stall holds the scan in emit
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= '0;
			wp_r <= 1'b0;
			rp_r <= 1'b0;
		end else begin
			if (buf_in_valid && buf_in_ready) begin
				wp_r <= !wp_r;
			end
			if (out_valid && out_ready) begin
				rp_r <= !rp_r;
			end
			cnt_r <= cnt_r + 2'(buf_in_valid && buf_in_ready) - 2'(out_valid && out_ready);
		end
	end

	// registered outputs
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_valid <= 1'b0;
			{out_port, out_vid, out_tag, out_high_prio, out_forward, out_learn} <= '0;
			in_ready <= 1'b0;
			busy <= 1'b0;
		end else begin
			in_ready <= (state_r == MFVI_ST_IDLE) && !in_valid;
			busy <= (state_r != MFVI_ST_IDLE);
			if (!out_valid || out_ready) begin
				if (cnt_r != 2'(0) && !(out_valid && cnt_r == 2'(1))) begin
					out_valid <= 1'b1;
					{out_port, out_vid, out_tag, out_high_prio, out_forward, out_learn} <=
						buf_q[out_valid ? !rp_r : rp_r];
				end else begin
					out_valid <= 1'b0;
				end
			end
		end
	end
endmodule : mfvi_filter

/* testbench/mfvi_sink.sv */
// far-side model that takes decisions, at times slowly
`timescale 1ns/1ps
module mfvi_sink (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic stall,
	output logic out_ready
);
	logic ph_r;
	// ready on every other cycle, never while stalled
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ph_r <= 1'b0;
		end else begin
			ph_r <= ~ph_r;
		end
	end
	assign out_ready = ph_r && !stall;
endmodule : mfvi_sink

/* testbench/mfvi_filter_checker.sv */
// port assertions for the ingress filter
`timescale 1ns/1ps
`include "mfvi_defs.svh"
module mfvi_filter_checker (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic in_valid,
	input wire logic in_ready,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic out_forward,
	input wire logic out_tag,
	input wire logic [`MFVI_VID_W-1:0] out_vid,
	input wire logic vlan_en,
	input wire logic cfg_we,
	input wire logic [`MFVI_VID_W-1:0] cfg_port_default_vlan_id,
	input wire logic busy,
	input wire logic cfg_err
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// decision holds while stalled
	property p_stand; out_valid && !out_ready |=> out_valid && $stable({out_forward, out_tag, out_vid}); endproperty
	a_stand: assert property (p_stand) else $error("decision moved");
	property p_vloff; out_valid && !vlan_en |-> !out_tag && out_vid == 12'h000; endproperty
	a_vloff: assert property (p_vloff) else $error("vlan off tagged");
	property p_vrng; out_valid && vlan_en |-> out_vid != 12'h000 && out_vid != 12'hFFF; endproperty
	a_vrng: assert property (p_vrng) else $error("vid range");
	property p_cfg; cfg_we |=> cfg_err == ($past(cfg_port_default_vlan_id) inside {12'h000, 12'hFFF}); endproperty
	a_cfg: assert property (p_cfg) else $error("cfg check");
	property p_take; in_valid && in_ready && !busy |=> ##1 busy; endproperty
	a_take: assert property (p_take) else $error("not taken");
	property p_scan; $rose(busy) |-> busy [*8]; endproperty
	a_scan: assert property (p_scan) else $error("scan short");
	property p_ans; $fell(busy) |-> ##[0:4] out_valid; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_rst; $rose(rst_b) |-> !out_valid && !busy && !cfg_err; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
endmodule : mfvi_filter_checker
bind mfvi_filter mfvi_filter_checker u_chk (.sys_clk, .rst_b, .in_valid, .in_ready, .out_valid, .out_ready,
	.out_forward, .out_tag, .out_vid, .vlan_en, .cfg_we, .cfg_port_default_vlan_id, .busy, .cfg_err);

/* testbench/tb_top.sv */
// self-checking bench for the ingress filter
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
	typedef struct packed {logic p; logic [47:0] s; logic [47:0] d; logic [15:0] e;} mfvi_row_t;
	logic sys_clk = 1'b0, rst_b = 1'b0, in_valid = 1'b0, in_tagged = 1'b0, tbl_we = 1'b0, tbl_sel_deny = 1'b0;
	logic tbl_entry_valid = 1'b0, tbl_high = 1'b0, vlan_en = 1'b0, cfg_we = 1'b0, cfg_egress_tag = 1'b0, stall = 1'b0;
	logic in_ready, out_ready, out_valid, out_forward, out_learn, out_high_prio, out_tag, busy, cfg_err;
	logic [0:0] in_port = 1'h0, out_port, tbl_port = 1'h0, cfg_port = 1'h0;
	logic [1:0] port_secure_en = 2'h1, port_upstream = 2'h0;
	logic [3:0] tbl_idx = 4'h0;
	logic [11:0] in_vid = 12'h005, out_vid, cfg_port_default_vlan_id = 12'h001;
	logic [47:0] in_sa = 48'h0, in_da = 48'h0, tbl_mac = 48'h0;
	int num_errors = 0, tests_run = 0;
	// secured port 0, A1 high on 0, B2 low on 1, D4 denied; {fwd, high, learn, tag, vid}
	mfvi_row_t rows [8] = '{'{0, 48'hA1, 48'hC3, 16'hC000}, '{1, 48'hA1, 48'hC3, 16'h0000},
		'{1, 48'hC3, 48'hE5, 16'hA000}, '{0, 48'hC3, 48'hA1, 16'h0000}, '{1, 48'hC3, 48'hB2, 16'hA000},
		'{1, 48'hC3, 48'hA1, 16'hE000}, '{1, 48'hC3, 48'hD4, 16'h0000}, '{1, 48'hD4, 48'hC3, 16'h0000}};
	mfvi_filter dut (.sys_clk, .rst_b, .in_valid, .in_ready, .in_port, .in_sa, .in_da, .in_tagged, .in_vid,
		.out_valid, .out_ready, .out_forward, .out_learn, .out_high_prio, .out_tag, .out_vid, .out_port, .tbl_we,
		.tbl_sel_deny, .tbl_idx, .tbl_entry_valid, .tbl_mac, .tbl_port, .tbl_high, .port_secure_en, .vlan_en,
		.cfg_we, .cfg_port, .cfg_port_default_vlan_id, .cfg_egress_tag, .port_upstream, .busy, .cfg_err);
	mfvi_sink u_sink (.sys_clk, .rst_b, .stall, .out_ready);
	// clock
	initial forever #12.5 sys_clk = ~sys_clk;
	task automatic tick(int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	// one table entry
	task automatic wt(logic d, logic [3:0] i, logic v, logic [47:0] m, logic p, logic h);
		@(posedge sys_clk);
		{tbl_we, tbl_sel_deny, tbl_idx, tbl_entry_valid, tbl_mac, tbl_port, tbl_high} <= {1'b1, d, i, v, m, p, h};
		@(posedge sys_clk);
		tbl_we <= 1'b0;
	endtask : wt
	// one port vlan write, then its refusal flag
	task automatic cfg(logic p, logic [11:0] v, logic t, logic err);
		@(posedge sys_clk);
		{cfg_we, cfg_port, cfg_port_default_vlan_id, cfg_egress_tag} <= {1'b1, p, v, t};
		@(posedge sys_clk);
		cfg_we <= 1'b0;
		@(posedge sys_clk);
		`CHK("cfg_err", err, cfg_err)
	endtask : cfg
	// offer a header through any running scan until a fresh scan has begun
	task automatic send(logic p, logic [47:0] s, logic [47:0] d);
		int k;
		k = 0;
		@(posedge sys_clk);
		{in_valid, in_port, in_sa, in_da} <= {1'b1, p, s, d};
		do @(posedge sys_clk); while (busy !== 1'b0 && k++ < 200);
		do @(posedge sys_clk); while (busy !== 1'b1 && k++ < 200);
		in_valid <= 1'b0;
	endtask : send
	// wait for a retired decision; details only matter when forwarded
	task automatic get(string n, logic [15:0] e);
		int k;
		k = 0;
		do @(posedge sys_clk); while (!(out_valid === 1'b1 && out_ready === 1'b1) && k++ < 200);
		`CHK(n, 1'b1, out_valid && out_ready)
		`CHK(n, e[15], out_forward)
		`CHK(n, in_port, out_port)
		if (e[15]) `CHK(n, e[14:0], {out_high_prio, out_learn, out_tag, out_vid})
		$display("test %s done", n);
	endtask : get
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out
	// watchdog
	initial begin
		#200us;
		num_errors++;
		close_out();
	end
	initial begin
		tick(4);
		rst_b <= 1'b1;
		tick(2);
		`CHK("reset", 3'h0, {busy, out_valid, cfg_err})
		send(0, 48'hA1, 48'hC3);
		get("empty", 16'h0000);
		wt(0, 4'h0, 1, 48'hA1, 0, 1);
		wt(0, 4'h1, 1, 48'hB2, 1, 0);
		wt(1, 4'h0, 1, 48'hD4, 0, 0);
		foreach (rows[i]) begin
			send(rows[i].p, rows[i].s, rows[i].d);
			get("row", rows[i].e);
		end
		port_secure_en <= 2'h0;
		send(1, 48'hA1, 48'hC3);
		get("unsecured", 16'hE000);
		port_secure_en <= 2'h1;
		wt(0, 4'h0, 0, 48'hA1, 0, 1);
		send(0, 48'hA1, 48'hC3);
		get("removed", 16'h0000);
		vlan_en <= 1'b1;
		port_upstream <= 2'h3;
		send(1, 48'hC3, 48'hE5);
		get("upstream", 16'hB001);
		port_upstream <= 2'h0;
		send(1, 48'hC3, 48'hE5);
		get("untag", 16'hA001);
		in_tagged <= 1'b1;
		send(1, 48'hC3, 48'hE5);
		get("tagged", 16'hA005);
		in_tagged <= 1'b0;
		cfg(1, 12'h000, 1, 1);
		cfg(1, 12'hFFF, 1, 1);
		cfg(1, 12'hFFE, 1, 0);
		cfg(0, 12'h001, 1, 0);
		wt(0, 4'h0, 1, 48'hA1, 0, 1);
		stall <= 1'b1;
		send(1, 48'hC3, 48'hE5);
		send(1, 48'hC3, 48'hA1);
		tick(30);
		`CHK("held", 1'b1, out_valid)
		stall <= 1'b0;
		get("first", 16'hBFFE);
		get("second", 16'hFFFE);
		close_out();
	end
endmodule : tb_top
